// ==== logic/hbc_defs.svh ====
// Purpose: Constants shared by both ends of the host bus control link.
// Assumes: A single 250 MHz clock on both ends.
// Notes: Times are in ns; the cycle counts are derived from them.
`ifndef HBC_DEFS_SVH
`define HBC_DEFS_SVH

// ----------------------------------------------------------------------
// Bus style strap codes
// ----------------------------------------------------------------------
`define HBC_STYLE_GENERIC 2'h0
`define HBC_STYLE_ECLK 2'h1
`define HBC_STYLE_DSTROBE 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HBC_CLK_PERIOD_NS 4
`define HBC_WAIT_NS 40
`define HBC_WAIT_CYCLES ((`HBC_WAIT_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)
`define HBC_SETUP_NS 8
`define HBC_SETUP_CYCLES ((`HBC_SETUP_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)
`define HBC_STROBE_NS 32
`define HBC_STROBE_CYCLES ((`HBC_STROBE_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)
`define HBC_HOLD_NS 16
`define HBC_HOLD_CYCLES ((`HBC_HOLD_NS + `HBC_CLK_PERIOD_NS - 1) / `HBC_CLK_PERIOD_NS)

`endif

// ==== logic/hbc_pkg.sv ====
// Purpose: Types shared by both ends of the host bus control link.
// Assumes: Nothing beyond the constants header.
// Notes: State codes are one-hot.
`default_nettype none

package hbc_pkg;

    // ------------------------------------------------------------------
    // Device end
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DEV_IDLE = 3'h1,
        DEV_BUSY = 3'h2,
        DEV_DONE = 3'h4
    } devState_e;

    typedef struct packed {
        logic [13:0] sync1;
        logic [13:0] sync2;
        devState_e state;
        logic [7:0] count;
        logic prevActive;
        logic prevWrite;
        logic waitAckO;
        logic waitAckOe;
        logic [7:0] dataO;
        logic dataOe;
        logic readStrobe;
        logic writeStrobe;
        logic [7:0] writeData;
    } dev_s;

    // ------------------------------------------------------------------
    // Host end
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        HOST_IDLE = 4'h1,
        HOST_SETUP = 4'h2,
        HOST_STROBE = 4'h4,
        HOST_RELEASE = 4'h8
    } hostState_e;

    typedef struct packed {
        logic [8:0] sync1;
        logic [8:0] sync2;
        hostState_e state;
        logic [7:0] count;
        logic isWrite;
        logic csN;
        logic writeDir;
        logic dataStrobe;
        logic addressStrobeN;
        logic [7:0] dataO;
        logic dataOe;
        logic reqReady;
        logic rspValid;
        logic [7:0] rspData;
    } host_s;

endpackage

`default_nettype wire

// ==== logic/hbc_if.sv ====
// Purpose: Pin bundle between the host and the device end.
// Assumes: Shared pins are resolved here from the output enables.
// Notes: The wait/acknowledge pin and the data bus float high when undriven.
`timescale 1ns/1ps
`default_nettype none

interface hbc_if;
    logic csN;
    logic writeDir;
    logic dataStrobe;
    logic addressStrobeN;
    logic waitAckO;
    logic waitAckOe;
    logic waitAckLine;
    logic [7:0] hostDataO;
    logic hostDataOe;
    logic [7:0] devDataO;
    logic devDataOe;
    logic [7:0] dataLine;

    // ------------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------------
    assign waitAckLine = waitAckOe ? waitAckO : 1'h1;
    assign dataLine = hostDataOe ? hostDataO :
                      (devDataOe ? devDataO : 8'hff);

    modport device (
        input csN, writeDir, dataStrobe, addressStrobeN, dataLine,
        output waitAckO, waitAckOe, devDataO, devDataOe
    );

    modport host (
        output csN, writeDir, dataStrobe, addressStrobeN, hostDataO,
        output hostDataOe,
        input waitAckLine, dataLine
    );
endinterface

`default_nettype wire

// ==== logic/host_bus_device.sv ====
// Purpose: Device end of the parallel host bus control pins.
// Assumes: All pin inputs, the strap included, are asynchronous.
// Notes: The wait pin doubles as the acknowledge pin in data-strobe style.
// Operation
// - Generic style latches data at write strobe rise.
// - Enable-clock style: write pin is direction, high reads.
// - Data-strobe style: write pin is direction per transfer.
// - Cycles accepted only while chip select low.
// - Generic style drives wait during a transfer.
// - Generic wait is active low.
// - Wait goes inactive when the transfer completes.
// - Wait/acknowledge released after completion until next.
// - Host may hold off until completion is signalled.
// - Enable-clock style leaves the wait pin unused.
// - Data-strobe style qualifies cycles with address strobe.
// - Unused address strobe input tied high.
// - Reset restores defaults and idles all outputs.
`timescale 1ns/1ps
`default_nettype none
`include "hbc_defs.svh"

module host_bus_device
    import hbc_pkg::*;
#(
    parameter logic [7:0] WAIT_CYCLES = 8'(`HBC_WAIT_CYCLES)
) (
    input wire logic clk,
    input wire logic rst_b,
    hbc_if.device bus,
    input wire logic [1:0] busStyle,
    input wire logic [7:0] readData,
    output logic readStrobe,
    output logic writeStrobe,
    output logic [7:0] writeData
);

    dev_s q;
    dev_s d;

    // ------------------------------------------------------------------
    // Synchronised pins
    // ------------------------------------------------------------------
    logic pinCsN;
    logic pinWriteDir;
    logic pinDataStrobe;
    logic pinAddrStrobeN;
    logic [1:0] pinStyle;
    logic [7:0] pinData;

    assign pinCsN = q.sync2[13];
    assign pinWriteDir = q.sync2[12];
    assign pinDataStrobe = q.sync2[11];
    assign pinAddrStrobeN = q.sync2[10];
    assign pinStyle = q.sync2[9:8];
    assign pinData = q.sync2[7:0];

    // ------------------------------------------------------------------
    // Bus style decode
    // ------------------------------------------------------------------
    // The strap shares the pin synchroniser, so a style change reaches
    // the decode in the same cycle as the pins that it governs.
    logic styleEclk;
    logic styleDstrobe;
    logic styleGeneric;

    assign styleEclk = (pinStyle == `HBC_STYLE_ECLK);
    assign styleDstrobe = (pinStyle == `HBC_STYLE_DSTROBE);
    // The unused fourth code falls back to the generic style.
    assign styleGeneric = !styleEclk && !styleDstrobe;

    // ------------------------------------------------------------------
    // Cycle qualification
    // ------------------------------------------------------------------
    logic eclkActive;
    logic dstrobeActive;
    logic genericActive;
    logic active;
    logic dirRead;

    assign eclkActive = !pinCsN && pinDataStrobe;
    assign dstrobeActive = !pinCsN && !pinAddrStrobeN &&
                           !pinDataStrobe;
    assign genericActive = !pinCsN &&
                           (!pinWriteDir || !pinDataStrobe);
    assign active = styleEclk ? eclkActive :
                    styleDstrobe ? dstrobeActive :
                    genericActive;
    // In the generic style a low read strobe alone marks a read.
    assign dirRead = styleGeneric ? !pinDataStrobe :
                     pinWriteDir;

    // ------------------------------------------------------------------
    // Write capture
    // ------------------------------------------------------------------
    // A write is taken as its cycle ends, when the data has settled.
    logic writeEnds;

    assign writeEnds = q.prevActive && !active && q.prevWrite;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.sync1 = {bus.csN,
                   bus.writeDir,
                   bus.dataStrobe,
                   bus.addressStrobeN,
                   busStyle,
                   bus.dataLine};
        d.sync2 = q.sync1;
        d.readStrobe = 1'h0;
        d.writeStrobe = 1'h0;
        d.prevActive = active;
        if (active) begin
            d.prevWrite = !dirRead;
        end
        if (writeEnds) begin
            d.writeStrobe = 1'h1;
            d.writeData = pinData;
        end

        // A completed transfer walks idle, busy and done in turn.
        unique case (q.state)
            DEV_IDLE: begin
                d.waitAckOe = 1'h0;
                d.dataOe = 1'h0;
                if (active) begin
                    d.state = DEV_BUSY;
                    d.count = WAIT_CYCLES;
                    if (dirRead) begin
                        d.readStrobe = 1'h1;
                        d.dataO = readData;
                        d.dataOe = 1'h1;
                    end
                    if (styleGeneric) begin
                        d.waitAckOe = 1'h1;
                        d.waitAckO = 1'h0;
                    end else if (styleDstrobe) begin
                        d.waitAckOe = 1'h1;
                        d.waitAckO = 1'h1;
                    end
                end
            end
            DEV_BUSY: begin
                // An early end drops the transfer without completion.
                if (!active) begin
                    d.state = DEV_IDLE;
                    d.waitAckOe = 1'h0;
                    d.dataOe = 1'h0;
                end else if (q.count > 8'h1) begin
                    d.count = q.count - 8'h1;
                end else begin
                    d.state = DEV_DONE;
                    d.count = 8'h0;
                    d.waitAckO = styleGeneric;
                end
            end
            DEV_DONE: begin
                if (!active) begin
                    d.state = DEV_IDLE;
                    d.waitAckOe = 1'h0;
                    d.dataOe = 1'h0;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // The synchroniser refills with idle pin levels.
            q.sync1 <= 14'h3fff;
            q.sync2 <= 14'h3fff;
            q.state <= DEV_IDLE;
            q.count <= 8'h0;
            q.prevActive <= 1'h0;
            q.prevWrite <= 1'h0;
            q.waitAckO <= 1'h1;
            q.waitAckOe <= 1'h0;
            q.dataO <= 8'h0;
            q.dataOe <= 1'h0;
            q.readStrobe <= 1'h0;
            q.writeStrobe <= 1'h0;
            q.writeData <= 8'h0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // Every output is driven straight from a register.
    assign bus.waitAckO = q.waitAckO;
    assign bus.waitAckOe = q.waitAckOe;
    assign bus.devDataO = q.dataO;
    assign bus.devDataOe = q.dataOe;
    assign readStrobe = q.readStrobe;
    assign writeStrobe = q.writeStrobe;
    assign writeData = q.writeData;

endmodule

`default_nettype wire

// ==== logic/host_bus_master.sv ====
// Purpose: Host end that runs single transfers over the control pins.
// Assumes: Bus style input is static and from this clock domain.
// Notes: Pin inputs from the device pass two flip-flops.
`timescale 1ns/1ps
`default_nettype none
`include "hbc_defs.svh"

module host_bus_master
    import hbc_pkg::*;
#(
    parameter logic [7:0] SETUP_CYCLES = 8'(`HBC_SETUP_CYCLES),
    parameter logic [7:0] STROBE_CYCLES = 8'(`HBC_STROBE_CYCLES),
    parameter logic [7:0] HOLD_CYCLES = 8'(`HBC_HOLD_CYCLES)
) (
    input wire logic clk,
    input wire logic rst_b,
    hbc_if.host bus,
    input wire logic [1:0] busStyle,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [7:0] reqData,
    output logic reqReady,
    output logic rspValid,
    output logic [7:0] rspData
);

    host_s q;
    host_s d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic isGeneric;
        logic isEclk;
        logic done;
        isGeneric = (busStyle != `HBC_STYLE_ECLK) &&
                    (busStyle != `HBC_STYLE_DSTROBE);
        isEclk = (busStyle == `HBC_STYLE_ECLK);
        done = 1'h0;
        d = q;
        d.sync1 = {bus.waitAckLine, bus.dataLine};
        d.sync2 = q.sync1;
        d.rspValid = 1'h0;

        if (isEclk) begin
            done = 1'h1;
        end else if (isGeneric) begin
            done = q.sync2[8];
        end else begin
            done = !q.sync2[8];
        end

        unique case (q.state)
            HOST_IDLE: begin
                d.dataStrobe = !isEclk;
                d.writeDir = 1'h1;
                if (reqValid && q.reqReady) begin
                    d.reqReady = 1'h0;
                    d.isWrite = reqWrite;
                    d.csN = 1'h0;
                    d.writeDir = isGeneric ? 1'h1 : !reqWrite;
                    d.addressStrobeN =
                        (busStyle == `HBC_STYLE_DSTROBE) ? 1'h0 : 1'h1;
                    d.dataO = reqData;
                    d.dataOe = reqWrite;
                    d.count = SETUP_CYCLES;
                    d.state = HOST_SETUP;
                end
            end
            HOST_SETUP: begin
                if (q.count > 8'h1) begin
                    d.count = q.count - 8'h1;
                end else begin
                    if (isGeneric && q.isWrite) begin
                        d.writeDir = 1'h0;
                    end else begin
                        d.dataStrobe = isEclk;
                    end
                    d.count = STROBE_CYCLES;
                    d.state = HOST_STROBE;
                end
            end
            HOST_STROBE: begin
                if (q.count > 8'h1) begin
                    d.count = q.count - 8'h1;
                end else if (done) begin
                    d.rspData = q.isWrite ? q.dataO : q.sync2[7:0];
                    d.dataStrobe = !isEclk;
                    if (isGeneric) begin
                        d.writeDir = 1'h1;
                    end
                    d.count = HOLD_CYCLES;
                    d.state = HOST_RELEASE;
                end
            end
            HOST_RELEASE: begin
                if (q.count > 8'h1) begin
                    d.count = q.count - 8'h1;
                end else begin
                    d.csN = 1'h1;
                    d.addressStrobeN = 1'h1;
                    d.writeDir = 1'h1;
                    d.dataOe = 1'h0;
                    d.rspValid = 1'h1;
                    d.reqReady = 1'h1;
                    d.count = 8'h0;
                    d.state = HOST_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q.sync1 <= 9'h1ff;
            q.sync2 <= 9'h1ff;
            q.state <= HOST_IDLE;
            q.count <= 8'h0;
            q.isWrite <= 1'h0;
            q.csN <= 1'h1;
            q.writeDir <= 1'h1;
            q.dataStrobe <= 1'h1;
            q.addressStrobeN <= 1'h1;
            q.dataO <= 8'h0;
            q.dataOe <= 1'h0;
            q.reqReady <= 1'h1;
            q.rspValid <= 1'h0;
            q.rspData <= 8'h0;
        end else begin
            q <= d;
        end
    end

    assign bus.csN = q.csN;
    assign bus.writeDir = q.writeDir;
    assign bus.dataStrobe = q.dataStrobe;
    assign bus.addressStrobeN = q.addressStrobeN;
    assign bus.hostDataO = q.dataO;
    assign bus.hostDataOe = q.dataOe;
    assign reqReady = q.reqReady;
    assign rspValid = q.rspValid;
    assign rspData = q.rspData;

endmodule

`default_nettype wire

// ==== dv/host_bus_assertions.sv ====
// Purpose: Timing checks on the host bus control pins.
// Assumes: Both ends share clk; pins are the interface signals, with the device wait and enables taken before resolution.
// Notes: Device pins lag host pins by two synchroniser flops and the output register.
`timescale 1ns/1ps
`default_nettype none
`include "hbc_defs.svh"

module host_bus_assertions (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] busStyle,
    input wire logic csN,
    input wire logic writeDir,
    input wire logic dataStrobe,
    input wire logic addressStrobeN,
    input wire logic waitAckO,
    input wire logic waitAckOe,
    input wire logic devDataOe
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic generic;
    assign generic = busStyle != `HBC_STYLE_ECLK &&
                     busStyle != `HBC_STYLE_DSTROBE;

    sequence s_waitStart;
        generic && $rose(waitAckOe);
    endsequence
    sequence s_waitHeld;
        !waitAckO [*8] ##[2:3] waitAckO;
    endsequence
    property p_waitLow;
        s_waitStart |-> !waitAckO;
    endproperty
    a_waitLow: assert property (p_waitLow)
        else $error("wait not low at start");
    property p_waitDone;
        s_waitStart |-> s_waitHeld;
    endproperty
    a_waitDone: assert property (p_waitDone)
        else $error("wait length wrong");
    property p_release;
        waitAckOe && $past(waitAckOe) && $changed(waitAckO)
            |-> ##[1:10] !waitAckOe;
    endproperty
    a_release: assert property (p_release)
        else $error("wait pin not released");
    property p_csGate;
        $rose(waitAckOe) || $rose(devDataOe) |-> !$past(csN, 2);
    endproperty
    a_csGate: assert property (p_csGate)
        else $error("answer without chip select");
    property p_idleQuiet;
        csN [*5] |-> !waitAckOe && !devDataOe;
    endproperty
    a_idleQuiet: assert property (p_idleQuiet)
        else $error("pins driven while deselected");
    property p_eclkNoWait;
        busStyle == `HBC_STYLE_ECLK |-> !waitAckOe;
    endproperty
    a_eclkNoWait: assert property (p_eclkNoWait)
        else $error("wait pin driven in enable-clock style");
    property p_strobeHigh;
        busStyle != `HBC_STYLE_DSTROBE |-> addressStrobeN;
    endproperty
    a_strobeHigh: assert property (p_strobeHigh)
        else $error("address strobe low outside data-strobe style");
    property p_dstrobeQual;
        busStyle == `HBC_STYLE_DSTROBE && $rose(waitAckOe)
            |-> !$past(addressStrobeN, 2) && !$past(dataStrobe, 2);
    endproperty
    a_dstrobeQual: assert property (p_dstrobeQual)
        else $error("cycle not qualified by address strobe");
    property p_readDir;
        !generic && $rose(devDataOe) |-> $past(writeDir, 2);
    endproperty
    a_readDir: assert property (p_readDir)
        else $error("data driven without read direction");
endmodule

`default_nettype wire

// ==== dv/host_bus_control_pins_bench.sv ====
// Purpose: Self-checking bench joining host and device ends.
// Assumes: Default timing parameters on both ends.
// Notes: Inputs change at the falling edge; pins are watched there too.
`timescale 1ns/1ps
`default_nettype none

module host_bus_control_pins_bench;
    // ------------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] style;
        logic wr;
        logic [7:0] data;
        logic [7:0] rsp;
    } row_s;
    row_s rows [8] = '{
        '{2'h0, 1'h1, 8'ha5, 8'ha5}, '{2'h0, 1'h0, 8'h5a, 8'h5a},
        '{2'h1, 1'h1, 8'h3c, 8'h3c}, '{2'h1, 1'h0, 8'hc3, 8'hc3},
        '{2'h2, 1'h1, 8'h81, 8'h81}, '{2'h2, 1'h0, 8'h7e, 8'h7e},
        '{2'h3, 1'h1, 8'hff, 8'hff}, '{2'h3, 1'h0, 8'h00, 8'h00}};
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [1:0] busStyle = 2'h0;
    logic reqValid = 1'h0;
    logic reqWrite = 1'h0;
    logic [7:0] reqData = 8'h00;
    logic [7:0] readData = 8'h00;
    logic reqReady, rspValid, readStrobe, writeStrobe;
    logic [7:0] rspData, writeData;
    logic waitSeenLow = 1'h0;
    logic addrStrobeSeenLow = 1'h0;
    logic dirPrev = 1'h1;
    logic [7:0] dataAtRise = 8'h00;
    int errCount = 0;
    int testsRun = 0;
    int cycles = 0;
    int rdPulses = 0;
    int wrPulses = 0;
    int rd0, wr0;
    hbc_if bus();

    host_bus_master i_host_bus_master (.clk(clk), .rst_b(rst_b),
        .bus(bus), .busStyle(busStyle), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqData(reqData), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData));
    host_bus_device i_host_bus_device (.clk(clk), .rst_b(rst_b),
        .bus(bus), .busStyle(busStyle), .readData(readData),
        .readStrobe(readStrobe), .writeStrobe(writeStrobe),
        .writeData(writeData));
    host_bus_assertions i_host_bus_assertions (.clk(clk), .rst_b(rst_b),
        .busStyle(busStyle), .csN(bus.csN), .writeDir(bus.writeDir),
        .dataStrobe(bus.dataStrobe), .addressStrobeN(bus.addressStrobeN),
        .waitAckO(bus.waitAckO), .waitAckOe(bus.waitAckOe),
        .devDataOe(bus.devDataOe));

    always #2 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errCount++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic printVerdict();
        $display("Comparisons %0d, mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // The ceiling is far above the few dozen cycles each transfer takes.
    always @(negedge clk) begin
        cycles++;
        rdPulses += int'(readStrobe === 1'h1);
        wrPulses += int'(writeStrobe === 1'h1);
        waitSeenLow |= bus.waitAckLine === 1'h0;
        addrStrobeSeenLow |= bus.addressStrobeN === 1'h0;
        if (!dirPrev && bus.writeDir === 1'h1 && bus.csN === 1'h0)
            dataAtRise = bus.dataLine;
        dirPrev = bus.writeDir;
        if (cycles == 20000) begin
            errCount++;
            printVerdict();
        end
    end

    task automatic xfer(input logic [1:0] style, input logic wr,
                        input logic [7:0] data, input logic gap);
        int n;
        n = 0;
        if (gap) begin
            busStyle = style;
            repeat (6) @(negedge clk);
        end
        readData = data;
        reqWrite = wr;
        reqData = data;
        reqValid = 1'h1;
        @(negedge clk);
        reqValid = 1'h0;
        check(reqReady, 1'h0);
        while (rspValid !== 1'h1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check(rspValid, 1'h1);
    endtask

    task automatic idleCheck();
        check(bus.csN, 1'h1);
        check(bus.waitAckLine, 1'h1);
        check(bus.dataLine, 8'hff);
        check(rspValid, 1'h0);
        check(reqReady, 1'h1);
    endtask

    initial begin
        repeat (4) @(negedge clk);
        idleCheck();
        check(writeData, 8'h00);
        repeat (4) @(negedge clk);
        rst_b = 1'h1;
        repeat (4) @(negedge clk);
        foreach (rows[i]) begin
            waitSeenLow = 1'h0;
            addrStrobeSeenLow = 1'h0;
            rd0 = rdPulses;
            wr0 = wrPulses;
            xfer(rows[i].style, rows[i].wr, rows[i].data, 1'h1);
            repeat (6) @(negedge clk);
            check(rspData, rows[i].rsp);
            check(8'(wrPulses - wr0), 8'(rows[i].wr));
            check(8'(rdPulses - rd0), 8'(!rows[i].wr));
            check(waitSeenLow, rows[i].style != 2'h1);
            check(addrStrobeSeenLow, rows[i].style == 2'h2);
            if (rows[i].wr)
                check(writeData, rows[i].data);
            if (rows[i].wr && rows[i].style[0] == rows[i].style[1])
                check(dataAtRise, rows[i].data);
        end
        busStyle = 2'h0;
        reqWrite = 1'h0;
        reqValid = 1'h1;
        @(negedge clk);
        reqValid = 1'h0;
        repeat (7) @(negedge clk);
        rst_b = 1'h0;
        @(negedge clk);
        idleCheck();
        repeat (3) @(negedge clk);
        rst_b = 1'h1;
        repeat (4) @(negedge clk);
        wr0 = wrPulses;
        xfer(2'h0, 1'h1, 8'h11, 1'h1);
        xfer(2'h0, 1'h1, 8'h22, 1'h0);
        repeat (6) @(negedge clk);
        check(rspData, 8'h22);
        check(writeData, 8'h22);
        check(8'(wrPulses - wr0), 8'h02);
        printVerdict();
    end
endmodule

`default_nettype wire
